// File: dv/ebg_bus_master.sv
// Two-wire bus master model on a 125 ns timebase
`timescale 1ns/100ps
module ebg_bus_master (
    input wire logic tick,
    input wire logic sda_w,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Phases of one to three ticks, clock pulses well above the filter
    task automatic wt(input int n);
        repeat (n) @(posedge tick);
    endtask
    task automatic start_c();
        sda = 1'b1;
        wt(1);
        scl = 1'b1;
        wt(2);
        sda = 1'b0;
        wt(2);
        scl = 1'b0;
        wt(1);
    endtask
    task automatic stop_c();
        sda = 1'b0;
        wt(1);
        scl = 1'b1;
        wt(2);
        sda = 1'b1;
        wt(3);
    endtask
    task automatic bit_c(input logic b, output logic s);
        sda = b;
        wt(2);
        scl = 1'b1;
        wt(1);
        s = sda_w;
        wt(2);
        scl = 1'b0;
        wt(1);
    endtask
    task automatic byte_c(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_c(d[i], s);
        bit_c(1'b1, s);
        ack = !s;
    endtask
    task automatic recover_c();
        logic s;
        start_c();
        byte_c(8'hFF, s);
        start_c();
        stop_c();
    endtask
    task automatic glitch_c();
        sda = 1'b0;
        #100;
        sda = 1'b1;
        wt(2);
        // A false start would shift the next byte into place
        scl = 1'b0;
        wt(1);
    endtask
endmodule

// File: dv/ebg_guard_monitor.sv
// Checker of the bus recovery guard outputs
`timescale 1ns/100ps
module ebg_guard_monitor (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic low_vcc,
    input wire logic write_done,
    input wire logic rd_bit,
    input wire ebg_pkg::ebg_wreq_t wreq_q,
    input wire logic write_go_q,
    input wire logic write_drop_q,
    input wire logic init_busy,
    input wire logic busy
);
    import ebg_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    AST_INIT_SILENT: assert property (init_busy |->
        !sda_oe && !write_go_q && !write_drop_q)
        else $error("activity during init");
    AST_INIT_DONE: assert property ($fell(init_busy) |-> !busy && !sda_oe)
        else $error("init ended with work pending");
    AST_ONE_OUTCOME: assert property ((write_go_q || write_drop_q) |->
        !(write_go_q && write_drop_q) ##1 !(write_go_q || write_drop_q))
        else $error("commit and drop not single exclusive pulses");
    AST_GO_BUSY: assert property (write_go_q |-> busy && !$past(busy))
        else $error("commit without fresh write cycle");
    AST_BUSY_QUIET: assert property (busy |-> !sda_oe)
        else $error("data driven during write cycle");
    AST_BUSY_HOLD: assert property (busy && !write_go_q |-> $stable(wreq_q))
        else $error("write request changed during write cycle");
    AST_DROP_IDLE: assert property (write_drop_q |-> !busy ##1 !busy)
        else $error("dropped write started a cycle");
    AST_OE_EDGE: assert property ($rose(sda_oe) || $fell(sda_oe) |-> !scl_i)
        else $error("data drive changed with clock high");
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data output not low");
    COV_GO: cover property (write_go_q);
    COV_DROP: cover property (write_drop_q);
    COV_RELEASE: cover property ($fell(sda_oe));
endmodule
bind ebg_guard ebg_guard_monitor ebg_guard_monitor_i (.mclk(mclk), .reset_n(reset_n),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .low_vcc(low_vcc),
    .write_done(write_done), .rd_bit(rd_bit), .wreq_q(wreq_q), .write_go_q(write_go_q),
    .write_drop_q(write_drop_q), .init_busy(init_busy), .busy(busy));

// File: dv/test_eeprom_bus_recovery_guard.sv
// Self-checking bench of the bus recovery guard
`timescale 1ns/100ps
module test_eeprom_bus_recovery_guard;
    import ebg_pkg::*;
    logic mclk = 1'b0;
    logic tick = 1'b0;
    logic reset_n = 1'b0;
    logic scl_i = 1'b1;
    logic sda_i = 1'b1;
    logic low_vcc = 1'b0;
    logic write_done = 1'b0;
    logic rd_bit = 1'b0;
    logic m_scl, m_sda, sda_w, sda_o, sda_oe, go, drop, init_busy, busy, a;
    ebg_wreq_t wreq;
    int go_n = 0;
    int drop_n = 0;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    ebg_guard #(.INIT_CYC(400)) ebg_guard_i (.mclk(mclk), .reset_n(reset_n), .scl_i(scl_i),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .low_vcc(low_vcc),
        .write_done(write_done), .rd_bit(rd_bit), .wreq_q(wreq), .write_go_q(go),
        .write_drop_q(drop), .init_busy(init_busy), .busy(busy));
    ebg_bus_master ebg_bus_master_i (.tick(tick), .sda_w(sda_w), .scl(m_scl), .sda(m_sda));
    // Pull-up wins unless the master or the device sinks
    assign sda_w = sda_oe ? (m_sda & sda_o) : m_sda;
    initial forever #4 mclk = ~mclk;
    initial begin
        #3.3;
        forever #62.5 tick = ~tick;
    end
    always @(negedge mclk) begin
        scl_i <= m_scl;
        sda_i <= sda_w;
    end
    always @(posedge mclk) begin
        go_n += (go === 1'b1);
        drop_n += (drop === 1'b1);
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_low(ref logic s);
        for (int i = 0; i < 3000 && s !== 1'b0; i++) @(posedge mclk);
    endtask
    task automatic t_init();
        check("init_busy", init_busy, 1);
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        check("ack in init", a, 0);
        wait_low(init_busy);
        check("busy after init", busy, 0);
        ebg_bus_master_i.stop_c();
        check("go after init", go_n, 0);
    endtask
    task automatic t_write(input logic lv);
        int g0;
        int d0;
        g0 = go_n;
        d0 = drop_n;
        @(negedge mclk) low_vcc = lv;
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        check("addr ack", a, 1);
        ebg_bus_master_i.byte_c(8'h12, a);
        ebg_bus_master_i.byte_c(8'h5A, a);
        check("data ack", a, 1);
        ebg_bus_master_i.stop_c();
        check("go", go_n - g0, !lv);
        check("drop", drop_n - d0, lv);
        check("wreq", wreq, 16'h125A);
        @(negedge mclk) low_vcc = 1'b0;
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        ebg_bus_master_i.stop_c();
        check("poll ack", a, lv);
        @(negedge mclk) write_done = 1'b1;
        @(negedge mclk) write_done = 1'b0;
        wait_low(busy);
        check("busy end", busy, 0);
    endtask
    task automatic t_cancel();
        int g0;
        g0 = go_n;
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        ebg_bus_master_i.byte_c(8'h12, a);
        ebg_bus_master_i.stop_c();
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        ebg_bus_master_i.byte_c(8'h12, a);
        ebg_bus_master_i.byte_c(8'h5A, a);
        // Start after a full byte discards it
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.stop_c();
        // Pointer unknown after a cancel, so reload it
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        ebg_bus_master_i.byte_c(8'h12, a);
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA1, a);
        check("read addr ack", a, 1);
        ebg_bus_master_i.bit_c(1'b1, a);
        check("read bit", a, 0);
        repeat (8) ebg_bus_master_i.bit_c(1'b1, a);
        ebg_bus_master_i.stop_c();
        check("go after cancel", go_n - g0, 0);
    endtask
    task automatic t_recover();
        ebg_bus_master_i.start_c();
        ebg_bus_master_i.byte_c(8'hA1, a);
        ebg_bus_master_i.bit_c(1'b1, a);
        check("hung drive", sda_oe, 1);
        ebg_bus_master_i.recover_c();
        check("released", sda_oe, 0);
        t_write(1'b0);
    endtask
    task automatic t_glitch();
        ebg_bus_master_i.glitch_c();
        ebg_bus_master_i.byte_c(8'hA0, a);
        check("glitch start", a, 0);
        ebg_bus_master_i.stop_c();
    endtask
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        t_init();
        t_write(1'b0);
        t_write(1'b1);
        t_cancel();
        t_recover();
        t_glitch();
        finish_test();
    end
endmodule

// File: logic/ebg_cfg.svh
// Timing and field constants for the bus recovery guard
`ifndef EBG_CFG_SVH
`define EBG_CFG_SVH
`define EBG_CLK_PERIOD_NS 8
`define EBG_GLITCH_NS 130
// Filter must hold a level longer than the glitch width
`define EBG_GLITCH_CYC ((`EBG_GLITCH_NS + `EBG_CLK_PERIOD_NS - 1) / `EBG_CLK_PERIOD_NS)
`define EBG_INIT_CYC 1000
`define EBG_CNT_W 4
`define EBG_LAST_BIT 4'h7
`define EBG_ACK_BIT 4'h8
// Marks the clock fall that closes a start, which carries no data bit
`define EBG_SKIP_BIT 4'hF
`define EBG_ADDR_RD_BIT 0
`define EBG_DEV_ID 7'h50
`endif

// File: logic/ebg_guard.sv
// Protocol-state guard of a two-wire EEPROM slave
`timescale 1ns/100ps
`include "ebg_cfg.svh"
module ebg_guard #(
    parameter int INIT_CYC = `EBG_INIT_CYC,
    parameter logic [6:0] DEV_ID = `EBG_DEV_ID // Arbitrary default address
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic low_vcc,
    input wire logic write_done,
    input wire logic rd_bit,
    output ebg_pkg::ebg_wreq_t wreq_q,
    output logic write_go_q,
    output logic write_drop_q,
    output logic init_busy,
    output logic busy
);
    import ebg_pkg::*;
    localparam int GW = 6;
    localparam logic [GW-1:0] GLITCH = GW'(`EBG_GLITCH_CYC);

    // Three-stage synchronisers for pins and undervoltage
    logic [2:0] scl_s_q, sda_s_q, lv_s_q;
    logic [2:0] scl_s_d, sda_s_d, lv_s_d;
    // Filtered levels and glitch counters
    logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;
    logic [GW-1:0] scl_c_q, scl_c_d, sda_c_q, sda_c_d;
    logic [31:0] init_q, init_d;
    ebg_state_t st_q, st_d;
    logic [`EBG_CNT_W-1:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic rd_q, rd_d, nack_q, nack_d, has_byte_q, has_byte_d, ack_q, ack_d;
    logic drv_q, drv_d, lv_q, lv_d, go_d, drop_d;
    ebg_wreq_t wreq_d;
    ebg_event_t ev;

    always_comb begin
        scl_s_d = {scl_s_q[1:0], scl_i};
        sda_s_d = {sda_s_q[1:0], sda_i};
        lv_s_d = {lv_s_q[1:0], low_vcc};
        scl_f_d = scl_f_q;
        scl_c_d = '0;
        if (scl_s_q[1] == scl_s_q[2] && scl_s_q[2] != scl_f_q) begin
            scl_c_d = scl_c_q + GW'(1);
            if (scl_c_q >= GLITCH) begin
                scl_f_d = scl_s_q[2];
                scl_c_d = '0;
            end
        end
        sda_f_d = sda_f_q;
        sda_c_d = '0;
        if (sda_s_q[1] == sda_s_q[2] && sda_s_q[2] != sda_f_q) begin
            sda_c_d = sda_c_q + GW'(1);
            if (sda_c_q >= GLITCH) begin
                sda_f_d = sda_s_q[2];
                sda_c_d = '0;
            end
        end
        lv_d = (lv_s_q[1] == lv_s_q[2]) ? lv_s_q[2] : lv_q;
        init_d = (init_q != 0) ? init_q - 1 : init_q;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            lv_s_q <= 3'h0;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_c_q <= '0;
            sda_c_q <= '0;
            lv_q <= 1'b0;
            init_q <= INIT_CYC;
        end else begin
            scl_s_q <= scl_s_d;
            sda_s_q <= sda_s_d;
            lv_s_q <= lv_s_d;
            scl_f_q <= scl_f_d;
            sda_f_q <= sda_f_d;
            scl_c_q <= scl_c_d;
            sda_c_q <= sda_c_d;
            lv_q <= lv_d;
            init_q <= init_d;
        end
    end

    assign init_busy = (init_q != 0);
    assign busy = (st_q == ST_WRITE);
    always_comb begin
        ev.start = scl_f_q && scl_f_d && sda_f_q && !sda_f_d;
        ev.stop = scl_f_q && scl_f_d && !sda_f_q && sda_f_d;
        ev.rise = !scl_f_q && scl_f_d;
        ev.fall = scl_f_q && !scl_f_d;
    end

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rd_d = rd_q;
        nack_d = nack_q;
        has_byte_d = has_byte_q;
        ack_d = ack_q;
        drv_d = drv_q;
        wreq_d = wreq_q;
        go_d = 1'b0;
        drop_d = 1'b0;
        if (init_busy) begin
            st_d = ST_IDLE;
            drv_d = 1'b0;
            has_byte_d = 1'b0;
        end else if (st_q == ST_WRITE) begin
            drv_d = 1'b0;
            if (write_done) begin
                st_d = ST_IDLE;
            end
        end else if (ev.start) begin
            st_d = ST_DEVADDR;
            // Clock still high here; its next fall is not a bit
            bit_d = `EBG_SKIP_BIT;
            has_byte_d = 1'b0;
            ack_d = 1'b0;
            drv_d = 1'b0;
        end else if (ev.stop) begin
            st_d = ST_IDLE;
            drv_d = 1'b0;
            // Commit only right after data acknowledge
            if (st_q == ST_WDATA && has_byte_q && bit_q == '0) begin
                if (lv_q) begin
                    drop_d = 1'b1;
                end else begin
                    go_d = 1'b1;
                    st_d = ST_WRITE;
                end
            end
            has_byte_d = 1'b0;
        end else if (st_q != ST_IDLE) begin
            if (ev.rise) begin
                if (bit_q == `EBG_ACK_BIT) begin
                    // Master acknowledge for reads
                    nack_d = sda_f_q;
                end else begin
                    sh_d = {sh_q[6:0], sda_f_q};
                end
            end
            if (ev.fall) begin
                drv_d = 1'b0;
                if (bit_q == `EBG_SKIP_BIT) begin
                    // Fall closing a start
                    bit_d = '0;
                end else if (bit_q == `EBG_ACK_BIT) begin
                    bit_d = '0;
                    ack_d = 1'b0;
                    // Master high on ack ends read
                    if (st_q == ST_RDATA && nack_q) begin
                        st_d = ST_IDLE;
                    end else if (st_q == ST_RDATA) begin
                        drv_d = !rd_bit;
                    end else if (!ack_q) begin
                        st_d = ST_IDLE;
                    end
                end else if (bit_q == `EBG_LAST_BIT) begin
                    bit_d = `EBG_ACK_BIT;
                    case (st_q)
                        ST_DEVADDR: begin
                            ack_d = (sh_q[7:1] == DEV_ID);
                            rd_d = sh_q[`EBG_ADDR_RD_BIT];
                            st_d = sh_q[`EBG_ADDR_RD_BIT] ? ST_RDATA : ST_WORDADDR;
                            if (sh_q[7:1] != DEV_ID) begin
                                st_d = ST_IDLE;
                            end
                        end
                        ST_WORDADDR: begin
                            ack_d = 1'b1;
                            wreq_d.waddr = sh_q;
                            st_d = ST_WDATA;
                        end
                        ST_WDATA: begin
                            ack_d = 1'b1;
                            wreq_d.wdata = sh_q;
                            has_byte_d = 1'b1;
                        end
                        default: begin
                            ack_d = 1'b0;
                        end
                    endcase
                    drv_d = (st_q != ST_RDATA) && (st_d != ST_IDLE);
                end else begin
                    bit_d = bit_q + `EBG_CNT_W'(1);
                    if (st_q == ST_RDATA) begin
                        drv_d = !rd_bit;
                    end
                end
                if (st_q == ST_DEVADDR && bit_q == `EBG_ACK_BIT && rd_q) begin
                    drv_d = !rd_bit;
                end
            end
            // Data seen high while driving low means master took line
            if (drv_q && sda_f_q && scl_f_q) begin
                drv_d = 1'b0;
                st_d = ST_IDLE;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            has_byte_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            wreq_q <= '0;
            write_go_q <= 1'b0;
            write_drop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            nack_q <= nack_d;
            has_byte_q <= has_byte_d;
            ack_q <= ack_d;
            drv_q <= drv_d;
            wreq_q <= wreq_d;
            write_go_q <= go_d;
            write_drop_q <= drop_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = drv_q;
endmodule

// File: logic/ebg_pkg.sv
// Types of the bus recovery guard
package ebg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_WORDADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_WRITE = 3'b101
    } ebg_state_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } ebg_event_t;
    typedef struct packed {
        logic [7:0] waddr;
        logic [7:0] wdata;
    } ebg_wreq_t;
endpackage
